// File: rtl/dtw_pkg.sv
/*
 * Shared constants for the dual timer and watchdog block: register byte
 * addresses, field positions, reset values, mode codes and counter sizes.
 * Assumes a 32-bit register bus with byte addresses and one word per register.
 */
package dtw_pkg;

    // =========================================================
    // register byte addresses
    localparam logic [31:0] ADDR_TIMER0_CONTROL_STATUS = 32'hfff81000;
    localparam logic [31:0] ADDR_TIMER1_CONTROL_STATUS = 32'hfff81004;
    localparam logic [31:0] ADDR_TIMER0_INITIAL_COUNT = 32'hfff81008;
    localparam logic [31:0] ADDR_TIMER1_INITIAL_COUNT = 32'hfff8100c;
    localparam logic [31:0] ADDR_TIMER0_CURRENT_COUNT = 32'hfff81010;
    localparam logic [31:0] ADDR_TIMER1_CURRENT_COUNT = 32'hfff81014;
    localparam logic [31:0] ADDR_TIMER_IRQ_FLAGS = 32'hfff81018;
    localparam logic [31:0] ADDR_WATCHDOG_CONTROL = 32'hfff8101c;

    // =========================================================
    // reset values
    localparam logic [31:0] RST_TIMER_CONTROL_STATUS = 32'h00000005;
    localparam logic [31:0] RST_WATCHDOG_CONTROL = 32'h00000400;

    // =========================================================
    // timer control/status fields
    localparam int TC_RUN_DBG = 31;
    localparam int TC_CEN = 30;
    localparam int TC_IE = 29;
    localparam int TC_MODE_LO = 27;
    localparam int TC_CLEAR = 26;
    localparam int TC_ACTIVE = 25;
    localparam int TC_PRESCALE_LO = 0;

    // =========================================================
    // watchdog control fields
    localparam int WD_DIV = 10;
    localparam int WD_DBG = 9;
    localparam int WD_TEST = 8;
    localparam int WD_EN = 7;
    localparam int WD_IE = 6;
    localparam int WD_SEL_LO = 4;
    localparam int WD_TFLAG = 3;
    localparam int WD_RFLAG = 2;
    localparam int WD_RSTE = 1;
    localparam int WD_RESTART = 0;

    // =========================================================
    // modes and sizes
    typedef enum logic [1:0] {
        MODE_ONE_SHOT = 2'b00,
        MODE_PERIODIC = 2'b01,
        MODE_TOGGLE = 2'b10,
        MODE_RESERVED = 2'b11
    } timer_mode_t;

    localparam int COUNT_W = 24;
    localparam int PRESCALE_W = 8;
    localparam int WD_COUNT_W = 26;
    localparam int WD_HALF_W = 13;
    localparam int WD_DIV_W = 8;
    localparam int WD_BASE_EXP = 14;
    localparam int WD_RESET_DELAY = 512;

endpackage

// File: rtl/timer_channel.sv
/*
 * One timer channel: prescale counter feeding a down counter with reload,
 * zero event pulse and toggle output.
 * Assumes i_tick is a one-cycle strobe per channel clock edge, synchronous.
 */
`timescale 1ns/10ps
module timer_channel #(
    parameter int COUNT_W = dtw_pkg::COUNT_W,
    parameter int PRESCALE_W = dtw_pkg::PRESCALE_W
) (
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic i_tick,
    input wire logic i_run,
    input wire logic i_restart,
    input wire logic i_clear,
    input wire logic i_toggle_mode,
    input wire logic [PRESCALE_W-1:0] i_prescale,
    input wire logic [COUNT_W-1:0] i_reload,
    output logic [COUNT_W-1:0] o_live_count,
    output logic o_zero,
    output logic o_tout
);
    typedef struct packed {
        logic [PRESCALE_W-1:0] pcnt;
        logic [COUNT_W-1:0] live;
        logic zero;
        logic tout;
    } chan_state_t;

    chan_state_t s;
    chan_state_t next_s;

    // =========================================================
    // counting
    always_comb begin
        next_s = s;
        next_s.zero = 1'b0;
        if (i_srst) begin
            next_s = '0;
        end else if (i_clear) begin
            next_s.pcnt = '0;
            next_s.live = '0;
        end else if (i_restart) begin
            next_s.pcnt = '0;
            next_s.live = i_reload;
        end else if (i_tick && i_run) begin
            if (s.pcnt == i_prescale) begin
                next_s.pcnt = '0;
                if (s.live == '0) begin
                    // counter was cleared: load without signalling
                    next_s.live = i_reload;
                end else if (s.live == COUNT_W'(1)) begin
                    next_s.live = i_reload;
                    next_s.zero = 1'b1;
                    if (i_toggle_mode) begin
                        next_s.tout = ~s.tout;
                    end
                end else begin
                    next_s.live = s.live - COUNT_W'(1);
                end
            end else begin
                next_s.pcnt = s.pcnt + PRESCALE_W'(1);
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        s <= next_s;
    end

    assign o_live_count = s.live;
    assign o_zero = s.zero;
    assign o_tout = s.tout;

endmodule

// File: rtl/wd_counter.sv
/*
 * Watchdog up counter, either one wide counter or two independent halves.
 * Assumes i_tick is the already divided and gated watchdog clock strobe.
 */
`timescale 1ns/10ps
module wd_counter #(
    parameter int WIDTH = dtw_pkg::WD_COUNT_W,
    parameter int HALF = dtw_pkg::WD_HALF_W
) (
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic i_clear,
    input wire logic i_tick,
    input wire logic i_split,
    output logic [WIDTH-1:0] o_count,
    output logic o_half_wrap
);
    typedef struct packed {
        logic [WIDTH-1:0] cnt;
        logic wrap;
    } wdc_state_t;

    wdc_state_t s;
    wdc_state_t next_s;
    logic [HALF-1:0] lo;
    logic [HALF-1:0] hi;

    // =========================================================
    // counting
    always_comb begin
        next_s = s;
        next_s.wrap = 1'b0;
        lo = s.cnt[HALF-1:0];
        hi = s.cnt[WIDTH-1:HALF];
        if (i_srst || i_clear) begin
            next_s = '0;
        end else if (i_tick) begin
            if (i_split) begin
                // halves run together so a test sees both overflow quickly
                next_s.cnt = {hi + HALF'(1), lo + HALF'(1)};
                next_s.wrap = (&lo) | (&hi);
            end else begin
                next_s.cnt = s.cnt + WIDTH'(1);
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        s <= next_s;
    end

    assign o_count = s.cnt;
    assign o_half_wrap = s.wrap;

endmodule

// File: rtl/dual_timer_watchdog.sv
/*
 * Two-channel timer plus watchdog with an APB register slave.
 * Assumes APB signals, channel clock strobes, the crystal strobe and the
 * debugger acknowledge are all synchronous to i_mclk.
 */
// Notes on behaviour
// - prescaler divides channel clock by value plus one
// - 24-bit down counter reloads on reaching zero
// - initial count write restarts from new value
// - mode selects one-shot, periodic or toggle
// - interrupt only when zero interrupt enabled
// - counter clear zeroes counters and count enable
// - active bit shows counter really running
// - debugger acknowledge freezes timer unless run enabled
// - per-channel zero flags, write one clears
// - live count readable, trusted only when stopped
// - watchdog divides crystal by 256, not test
// - debugger acknowledge freezes watchdog unless allowed
// - test mode splits counter into two halves
// - enable low stops and clears watchdog
// - interval select picks timeout two to 14..20
// - system reset follows timeout after fixed delay, not in test mode
// - timeout flag always set, interrupt only enabled
// - reset flag survives system reset, write-one clears
// - reset enable gates the system reset
// - restart bit clears watchdog count, self clears
// - registers reached through APB slave
`timescale 1ns/10ps
module dual_timer_watchdog #(
    parameter int COUNT_W = dtw_pkg::COUNT_W,
    parameter int PRESCALE_W = dtw_pkg::PRESCALE_W,
    parameter int WD_RESET_DELAY = dtw_pkg::WD_RESET_DELAY
) (
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic i_por_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [1:0] i_channel_clock,
    input wire logic i_debugger_ack_input,
    input wire logic i_xtal_tick,
    output logic [1:0] o_timer_irq,
    output logic [1:0] o_timer_out,
    output logic o_wd_irq,
    output logic o_wd_sys_reset
);
    localparam int DLY_W = $clog2(WD_RESET_DELAY + 1);
    localparam int WCW = dtw_pkg::WD_COUNT_W;

    typedef struct packed {
        logic [1:0] run_during_debug;
        logic [1:0] count_enable;
        logic [1:0] zero_irq_enable;
        logic [1:0][1:0] mode;
        logic [1:0][PRESCALE_W-1:0] prescale;
        logic [1:0][COUNT_W-1:0] reload_value;
        logic [1:0] restart;
        logic [1:0] counter_clear;
        logic chan0_zero_flag;
        logic chan1_zero_flag;
        logic wd_clock_div256;
        logic wd_run_during_debug;
        logic wd_test_mode;
        logic wd_enable;
        logic wd_irq_enable;
        logic [1:0] wd_interval_select;
        logic wd_timeout_flag;
        logic wd_reset_flag;
        logic wd_reset_enable;
        logic wd_restart;
        logic [dtw_pkg::WD_DIV_W-1:0] wd_pre;
        logic expired;
        logic [DLY_W-1:0] delay;
        logic sys_rst;
        logic [31:0] rdata;
    } dtw_state_t;

    dtw_state_t s;
    dtw_state_t next_s;

    // =========================================================
    // bus decode
    logic wr;
    logic rd_setup;
    logic hit_ctl0;
    logic hit_ctl1;
    logic hit_init0;
    logic hit_init1;
    logic hit_cur0;
    logic hit_cur1;
    logic hit_flags;
    logic hit_wd;
    logic mapped;

    assign wr = i_psel && i_penable && i_pwrite;
    assign rd_setup = i_psel && !i_penable && !i_pwrite;
    assign hit_ctl0 = (i_paddr == dtw_pkg::ADDR_TIMER0_CONTROL_STATUS);
    assign hit_ctl1 = (i_paddr == dtw_pkg::ADDR_TIMER1_CONTROL_STATUS);
    assign hit_init0 = (i_paddr == dtw_pkg::ADDR_TIMER0_INITIAL_COUNT);
    assign hit_init1 = (i_paddr == dtw_pkg::ADDR_TIMER1_INITIAL_COUNT);
    assign hit_cur0 = (i_paddr == dtw_pkg::ADDR_TIMER0_CURRENT_COUNT);
    assign hit_cur1 = (i_paddr == dtw_pkg::ADDR_TIMER1_CURRENT_COUNT);
    assign hit_flags = (i_paddr == dtw_pkg::ADDR_TIMER_IRQ_FLAGS);
    assign hit_wd = (i_paddr == dtw_pkg::ADDR_WATCHDOG_CONTROL);
    assign mapped = hit_ctl0 | hit_ctl1 | hit_init0 | hit_init1 | hit_cur0 | hit_cur1 |
        hit_flags | hit_wd;

    // zero wait states; unmapped access ends with an error
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel && i_penable && !mapped;
    assign o_prdata = s.rdata;

    // =========================================================
    // timer channels
    logic [1:0] ctl_hit;
    logic [1:0] init_hit;
    logic [1:0] held;
    logic [1:0] run;
    logic [1:0] zero;
    logic [1:0] active;
    logic [1:0] zero_flags;
    logic [1:0][COUNT_W-1:0] live_count;

    assign ctl_hit = {hit_ctl1, hit_ctl0};
    assign init_hit = {hit_init1, hit_init0};
    assign zero_flags = {s.chan1_zero_flag, s.chan0_zero_flag};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_chan
            assign held[g] = i_debugger_ack_input && !s.run_during_debug[g];
            assign run[g] = s.count_enable[g] && !held[g];
            assign active[g] = run[g];
            timer_channel #(
                .COUNT_W(COUNT_W),
                .PRESCALE_W(PRESCALE_W)
            ) u_chan (
                .i_mclk(i_mclk),
                .i_srst(i_srst),
                .i_tick(i_channel_clock[g]),
                .i_run(run[g]),
                .i_restart(s.restart[g]),
                .i_clear(s.counter_clear[g]),
                .i_toggle_mode(s.mode[g] == dtw_pkg::MODE_TOGGLE),
                .i_prescale(s.prescale[g]),
                .i_reload(s.reload_value[g]),
                .o_live_count(live_count[g]),
                .o_zero(zero[g]),
                .o_tout(o_timer_out[g])
            );
        end
    endgenerate

    assign o_timer_irq = zero_flags & s.zero_irq_enable;

    // =========================================================
    // watchdog clocking and counter
    logic wd_held;
    logic wd_xtick;
    logic wd_tick;
    logic wd_clear;
    logic wd_half_wrap;
    logic wd_timeout;
    logic [4:0] wd_shift;
    logic [WCW-1:0] wd_limit_m1;
    logic [WCW-1:0] wd_count;

    assign wd_held = i_debugger_ack_input && !s.wd_run_during_debug;
    assign wd_xtick = i_xtal_tick && s.wd_enable && !wd_held;
    // test mode always runs on the undivided clock
    assign wd_tick = wd_xtick &&
        ((s.wd_clock_div256 && !s.wd_test_mode) ? (&s.wd_pre) : 1'b1);
    assign wd_clear = !s.wd_enable || s.wd_restart;
    assign wd_shift = 5'(dtw_pkg::WD_BASE_EXP) + {2'b00, s.wd_interval_select, 1'b0};
    assign wd_limit_m1 = (WCW'(1) << wd_shift) - WCW'(1);
    assign wd_timeout = s.wd_test_mode ? wd_half_wrap :
        (wd_tick && !s.expired && (wd_count == wd_limit_m1));

    wd_counter #(
        .WIDTH(WCW),
        .HALF(dtw_pkg::WD_HALF_W)
    ) u_wd_count (
        .i_mclk(i_mclk),
        .i_srst(i_srst),
        .i_clear(wd_clear),
        .i_tick(wd_tick),
        .i_split(s.wd_test_mode),
        .o_count(wd_count),
        .o_half_wrap(wd_half_wrap)
    );

    assign o_wd_irq = s.wd_timeout_flag && s.wd_irq_enable;
    assign o_wd_sys_reset = s.sys_rst;

    // =========================================================
    // register and control next state
    always_comb begin
        next_s = s;
        next_s.restart = '0;
        next_s.counter_clear = '0;
        next_s.wd_restart = 1'b0;
        next_s.sys_rst = 1'b0;

        // timer control and reload writes
        for (int i = 0; i < 2; i++) begin
            if (wr && ctl_hit[i]) begin
                next_s.run_during_debug[i] = i_pwdata[dtw_pkg::TC_RUN_DBG];
                next_s.count_enable[i] = i_pwdata[dtw_pkg::TC_CEN];
                next_s.zero_irq_enable[i] = i_pwdata[dtw_pkg::TC_IE];
                next_s.mode[i] = i_pwdata[dtw_pkg::TC_MODE_LO +: 2];
                next_s.prescale[i] = i_pwdata[dtw_pkg::TC_PRESCALE_LO +: PRESCALE_W];
                if (i_pwdata[dtw_pkg::TC_CLEAR]) begin
                    next_s.counter_clear[i] = 1'b1;
                    next_s.count_enable[i] = 1'b0;
                end
            end
            if (wr && init_hit[i]) begin
                next_s.reload_value[i] = i_pwdata[COUNT_W-1:0];
                next_s.restart[i] = 1'b1;
            end
            // one-shot ends itself after its single zero
            if (zero[i] && s.mode[i] == dtw_pkg::MODE_ONE_SHOT) begin
                next_s.count_enable[i] = 1'b0;
            end
        end

        // zero flags: a zero event in the clearing cycle still sets
        if (wr && hit_flags && i_pwdata[0]) begin
            next_s.chan0_zero_flag = 1'b0;
        end
        if (wr && hit_flags && i_pwdata[1]) begin
            next_s.chan1_zero_flag = 1'b0;
        end
        if (zero[0]) begin
            next_s.chan0_zero_flag = 1'b1;
        end
        if (zero[1]) begin
            next_s.chan1_zero_flag = 1'b1;
        end

        // watchdog control writes
        if (wr && hit_wd) begin
            next_s.wd_clock_div256 = i_pwdata[dtw_pkg::WD_DIV];
            next_s.wd_run_during_debug = i_pwdata[dtw_pkg::WD_DBG];
            next_s.wd_test_mode = i_pwdata[dtw_pkg::WD_TEST];
            next_s.wd_enable = i_pwdata[dtw_pkg::WD_EN];
            next_s.wd_irq_enable = i_pwdata[dtw_pkg::WD_IE];
            next_s.wd_interval_select = i_pwdata[dtw_pkg::WD_SEL_LO +: 2];
            next_s.wd_reset_enable = i_pwdata[dtw_pkg::WD_RSTE];
            next_s.wd_restart = i_pwdata[dtw_pkg::WD_RESTART];
            if (i_pwdata[dtw_pkg::WD_TFLAG]) begin
                next_s.wd_timeout_flag = 1'b0;
            end
            if (i_pwdata[dtw_pkg::WD_RFLAG]) begin
                next_s.wd_reset_flag = 1'b0;
            end
        end

        // watchdog prescaler
        if (wd_clear) begin
            next_s.wd_pre = '0;
        end else if (wd_xtick) begin
            next_s.wd_pre = s.wd_pre + dtw_pkg::WD_DIV_W'(1);
        end

        // timeout, then the reset delay counted in watchdog clocks
        if (wd_clear) begin
            next_s.expired = 1'b0;
            next_s.delay = '0;
        end else if (wd_timeout) begin
            next_s.wd_timeout_flag = 1'b1;
            next_s.expired = !s.wd_test_mode;
            next_s.delay = '0;
        end else if (s.expired && wd_tick) begin
            if (s.delay == DLY_W'(WD_RESET_DELAY - 1)) begin
                next_s.expired = 1'b0;
                if (s.wd_reset_enable) begin
                    next_s.sys_rst = 1'b1;
                    next_s.wd_reset_flag = 1'b1;
                end
            end else begin
                next_s.delay = s.delay + DLY_W'(1);
            end
        end

        // read data captured in the setup phase, valid in the access phase
        if (rd_setup) begin
            next_s.rdata = '0;
            for (int i = 0; i < 2; i++) begin
                if (ctl_hit[i]) begin
                    next_s.rdata[dtw_pkg::TC_RUN_DBG] = s.run_during_debug[i];
                    next_s.rdata[dtw_pkg::TC_CEN] = s.count_enable[i];
                    next_s.rdata[dtw_pkg::TC_IE] = s.zero_irq_enable[i];
                    next_s.rdata[dtw_pkg::TC_MODE_LO +: 2] = s.mode[i];
                    next_s.rdata[dtw_pkg::TC_ACTIVE] = active[i];
                    next_s.rdata[dtw_pkg::TC_PRESCALE_LO +: PRESCALE_W] = s.prescale[i];
                end
                if (init_hit[i]) begin
                    next_s.rdata[COUNT_W-1:0] = s.reload_value[i];
                end
            end
            if (hit_cur0) begin
                next_s.rdata[COUNT_W-1:0] = live_count[0];
            end
            if (hit_cur1) begin
                next_s.rdata[COUNT_W-1:0] = live_count[1];
            end
            if (hit_flags) begin
                next_s.rdata[1:0] = zero_flags;
            end
            if (hit_wd) begin
                next_s.rdata[dtw_pkg::WD_DIV] = s.wd_clock_div256;
                next_s.rdata[dtw_pkg::WD_DBG] = s.wd_run_during_debug;
                next_s.rdata[dtw_pkg::WD_TEST] = s.wd_test_mode;
                next_s.rdata[dtw_pkg::WD_EN] = s.wd_enable;
                next_s.rdata[dtw_pkg::WD_IE] = s.wd_irq_enable;
                next_s.rdata[dtw_pkg::WD_SEL_LO +: 2] = s.wd_interval_select;
                next_s.rdata[dtw_pkg::WD_TFLAG] = s.wd_timeout_flag;
                next_s.rdata[dtw_pkg::WD_RFLAG] = s.wd_reset_flag;
                next_s.rdata[dtw_pkg::WD_RSTE] = s.wd_reset_enable;
            end
        end

        // system reset keeps the reset-cause flag; only power-on clears it
        if (i_srst || i_por_rst) begin
            next_s = '0;
            for (int i = 0; i < 2; i++) begin
                next_s.prescale[i] = dtw_pkg::RST_TIMER_CONTROL_STATUS[PRESCALE_W-1:0];
            end
            next_s.wd_clock_div256 = dtw_pkg::RST_WATCHDOG_CONTROL[dtw_pkg::WD_DIV];
            next_s.wd_reset_flag = i_por_rst ? 1'b0 : s.wd_reset_flag;
        end
    end

    always_ff @(posedge i_mclk) begin
        s <= next_s;
    end

endmodule

// File: verif/tick_source.sv
/* stand-in for the channel clock and crystal sources; assumes strobes are seen at i_mclk. */
`timescale 1ns/10ps
module tick_source (
    input wire logic i_mclk,
    input wire logic [1:0] i_ch_en,
    input wire logic i_xtal_en,
    output logic [1:0] o_channel_clock = 2'b00,
    output logic o_xtal_tick = 1'b0
);
    // =========
    // strobes
    logic ph = 1'b0;
    // channel 1 ticks at half rate so a slow source is exercised too
    always_ff @(posedge i_mclk) begin
        ph <= !ph;
        o_channel_clock <= {i_ch_en[1] && ph, i_ch_en[0]};
        o_xtal_tick <= i_xtal_en;
    end
endmodule

// File: verif/dtw_checker_assertions.sv
/* port assertions for the timer block; assumes one clock and synchronous resets. */
`timescale 1ns/10ps
module dtw_checker (
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic i_por_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [1:0] i_channel_clock,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic [1:0] o_timer_irq,
    input wire logic [1:0] o_timer_out,
    input wire logic o_wd_irq,
    input wire logic o_wd_sys_reset
);
    // =========
    // helpers: zero events lag a channel tick by a few cycles
    logic [3:0] hist;
    logic rst_d;
    logic acc;
    assign acc = i_psel && i_penable;
    always_ff @(posedge i_mclk) begin
        hist <= {hist[2:0], |i_channel_clock};
        rst_d <= i_srst || i_por_rst;
    end
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_srst || i_por_rst);
    ready_a: assert property (o_pready)
        else $error("pready low");
    err_phase_a: assert property (o_pslverr |-> acc)
        else $error("slverr outside access");
    unmapped_err_a: assert property (acc && i_paddr == 32'hfff81020 |-> o_pslverr)
        else $error("no slverr on unmapped address");
    reset_pulse_a: assert property (o_wd_sys_reset |=> !o_wd_sys_reset)
        else $error("system reset pulse too long");
    reset_quiet_a: assert property (disable iff (i_por_rst) i_srst |=> o_timer_irq == 2'b00
        && !o_wd_irq && o_timer_out == 2'b00 && !o_wd_sys_reset && o_prdata == 32'h0)
        else $error("outputs active after reset");
    tout_tick_a: assert property ($changed(o_timer_out) && !rst_d |-> hist != 4'h0)
        else $error("toggle output moved without a tick");
    prdata_hold_a: assert property (!$past(i_psel && !i_penable && !i_pwrite) && !rst_d
        |-> $stable(o_prdata))
        else $error("read data moved outside read setup");
    flag_clear_a: assert property (acc && i_pwrite && i_paddr == 32'hfff81018
        && i_pwdata[1:0] == 2'b11 && hist == 4'h0 && i_channel_clock == 2'b00
        |=> o_timer_irq == 2'b00)
        else $error("timer irq stays after flag clear");
    cover property ($rose(o_timer_irq[0]));
    cover property ($changed(o_timer_out[1]));
    cover property (o_wd_sys_reset);
endmodule
bind dual_timer_watchdog dtw_checker i_chk (.i_mclk, .i_srst, .i_por_rst, .i_psel, .i_penable,
    .i_pwrite, .i_paddr, .i_pwdata, .i_channel_clock, .o_prdata, .o_pready, .o_pslverr,
    .o_timer_irq, .o_timer_out, .o_wd_irq, .o_wd_sys_reset);

// File: verif/tb.sv
/* register tests of the timer block over apb; assumes tick_source and the bound checker. */
`timescale 1ns/10ps
module tb;
    // =========
    // signals and instances
    logic i_mclk = 1'b0, i_srst = 1'b1, i_por_rst = 1'b1, i_psel = 1'b0, i_penable = 1'b0;
    logic i_pwrite = 1'b0, i_debugger_ack_input = 1'b0, xt_en = 1'b0, e;
    logic [31:0] i_paddr = 32'h0, i_pwdata = 32'h0, o_prdata, d;
    logic [1:0] ch_en = 2'b00, i_channel_clock, o_timer_irq, o_timer_out;
    logic o_pready, o_pslverr, i_xtal_tick, o_wd_irq, o_wd_sys_reset;
    logic [3:0] w;
    int bad_count = 0, tests_run = 0, cyc;
    localparam logic [31:0] base = dtw_pkg::ADDR_TIMER0_CONTROL_STATUS;
    assign w = {o_wd_sys_reset, o_wd_irq, o_timer_out[1], o_timer_irq[0]};
    dual_timer_watchdog #(.WD_RESET_DELAY(4)) i_dut (.i_mclk, .i_srst, .i_por_rst, .i_psel,
        .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
        .i_channel_clock, .i_debugger_ack_input, .i_xtal_tick, .o_timer_irq, .o_timer_out,
        .o_wd_irq, .o_wd_sys_reset);
    tick_source i_src (.i_mclk, .i_ch_en(ch_en), .i_xtal_en(xt_en),
        .o_channel_clock(i_channel_clock), .o_xtal_tick(i_xtal_tick));
    initial begin
        forever #5 i_mclk = ~i_mclk;
    end
    // =========
    // tasks
    task chk(input string n, input logic [31:0] s, x);
        tests_run++;
        if (s !== x) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, x, s);
        end
    endtask
    task bus(input logic [31:0] a, v, input logic wr);
        @(posedge i_mclk);
        i_psel <= 1'b1;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= v;
        @(posedge i_mclk);
        i_penable <= 1'b1;
        @(posedge i_mclk);
        d = o_prdata;
        e = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask
    task tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // bounded wait for w[k] to reach v, cycles waited in cyc
    task wt(input int k, input logic v, input int n);
        cyc = 0;
        while (w[k] !== v) begin
            @(posedge i_mclk);
            #1;
            cyc++;
            if (cyc > n) begin
                bad_count++;
                tally_and_finish();
            end
        end
    endtask
    // =========
    // sequence
    initial begin
        repeat (20) @(posedge i_mclk);
        i_srst <= 1'b0;
        i_por_rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            bus(base + 32'(4 * i), 32'h0, 1'b0);
            chk("reset value", d, i < 2 ? 32'h5 : (i == 7 ? 32'h400 : 32'h0));
        end
        bus(base + 32'h20, 32'h0, 1'b0);
        chk("unmapped data", d, 32'h0);
        chk("unmapped error", 32'(e), 32'h1);
        $display("test registers done");
        ch_en <= 2'b01;
        bus(base + 32'h8, 32'h3, 1'b1);
        bus(base, 32'h68000000, 1'b1);
        wt(0, 1'b1, 20);
        ch_en <= 2'b00;
        bus(base + 32'h18, 32'h0, 1'b0);
        chk("zero flags", d, 32'h1);
        bus(base + 32'h18, 32'h3, 1'b1);
        bus(base + 32'h18, 32'h0, 1'b0);
        chk("flags cleared", d, 32'h0);
        bus(base, 32'h0, 1'b1);
        bus(base + 32'h8, 32'h5, 1'b1);
        bus(base + 32'h10, 32'h0, 1'b0);
        chk("restart count", d, 32'h5);
        bus(base, 32'h44000000, 1'b1);
        bus(base + 32'h10, 32'h0, 1'b0);
        chk("cleared count", d, 32'h0);
        bus(base, 32'h0, 1'b0);
        chk("clear stops", d & 32'h40000000, 32'h0);
        ch_en <= 2'b01;
        bus(base + 32'h8, 32'h2, 1'b1);
        bus(base, 32'h60000000, 1'b1);
        wt(0, 1'b1, 20);
        bus(base, 32'h0, 1'b0);
        chk("one shot stop", d & 32'h42000000, 32'h0);
        i_debugger_ack_input <= 1'b1;
        bus(base + 32'h8, 32'h64, 1'b1);
        bus(base, 32'h48000000, 1'b1);
        bus(base, 32'h0, 1'b0);
        chk("held inactive", d & 32'h42000000, 32'h40000000);
        bus(base, 32'h08000000, 1'b1);
        bus(base + 32'h10, 32'h0, 1'b0);
        chk("held count", d, 32'h64);
        i_debugger_ack_input <= 1'b0;
        bus(base, 32'h48000000, 1'b1);
        bus(base, 32'h0, 1'b0);
        chk("active", d & 32'h42000000, 32'h42000000);
        bus(base, 32'h04000000, 1'b1);
        ch_en <= 2'b10;
        bus(base + 32'hc, 32'h2, 1'b1);
        bus(base + 32'h4, 32'h70000001, 1'b1);
        wt(1, 1'b1, 40);
        wt(1, 1'b0, 40);
        chk("half period", 32'(cyc), 32'h8);
        chk("ch1 irq", 32'(o_timer_irq[1]), 32'h1);
        ch_en <= 2'b00;
        $display("test timers done");
        xt_en <= 1'b1;
        bus(base + 32'h1c, 32'hc2, 1'b1);
        wt(2, 1'b1, 16400);
        chk("wd interval", 32'(cyc >= 16380 && cyc <= 16390), 32'h1);
        wt(3, 1'b1, 20);
        chk("reset delay", 32'(cyc >= 2 && cyc <= 6), 32'h1);
        bus(base + 32'h1c, 32'h0, 1'b0);
        chk("wd flags", d, 32'hce);
        i_srst <= 1'b1;
        repeat (3) @(posedge i_mclk);
        i_srst <= 1'b0;
        bus(base + 32'h1c, 32'h0, 1'b0);
        chk("flag survives", d, 32'h404);
        i_por_rst <= 1'b1;
        repeat (3) @(posedge i_mclk);
        i_por_rst <= 1'b0;
        bus(base + 32'h1c, 32'h80, 1'b1);
        repeat (12000) @(posedge i_mclk);
        bus(base + 32'h1c, 32'h81, 1'b1);
        repeat (12000) @(posedge i_mclk);
        bus(base + 32'h1c, 32'h0, 1'b0);
        chk("restarted", d, 32'h80);
        bus(base + 32'h1c, 32'h0, 1'b1);
        bus(base + 32'h1c, 32'h5c0, 1'b1);
        wt(2, 1'b1, 8300);
        chk("split count", 32'(cyc >= 8185 && cyc <= 8200), 32'h1);
        $display("test watchdog done");
        tally_and_finish();
    end
endmodule
